// ==== shared/msk_pkg.sv ====
/*
  Constants of the modem control block: control word layout, reset value,
  standby mode numbers, divider and clock recovery counts, input indices.
  Assumes the system clock is the crystal oscillator clock of the device.
*/
`default_nettype none
package msk_pkg;
  // Control word layout.
  localparam int          CW_W          = 16;
  localparam logic [15:0] CTRL_RESET    = 16'h0004;
  localparam int          STBY_LSB      = 0;
  localparam int          STBY_W        = 3;
  localparam int          RXMUTE_BIT    = 3;
  localparam int          TXMUTE_BIT    = 4;
  localparam int          PREEMPH_BIT   = 5;
  localparam int          DEEMPH_BIT    = 6;
  localparam int          COMP_BIT      = 7;
  localparam int          TONE_BIT      = 8;
  localparam int          XTAL_BIT      = 9;
  localparam int          TEST_LSB      = 10;
  localparam int          TEST_W        = 6;
  // Standby mode numbers.
  localparam logic [2:0]  MODE_ALL_ON   = 3'h0;
  localparam logic [2:0]  MODE_NO_MODEM = 3'h1;
  localparam logic [2:0]  MODE_NO_TX    = 3'h2;
  localparam logic [2:0]  MODE_NO_RXVF  = 3'h3;
  localparam logic [2:0]  MODE_OSC_ONLY = 3'h4;
  localparam logic [2:0]  MODE_ALL_OFF  = 3'h5;
  // Crystal and bit timing.
  localparam int          XTAL_A_HZ     = 3686400;
  localparam int          XTAL_B_HZ     = 3456000;
  localparam int          BIT_RATE      = 1200;
  localparam int          OVERSAMPLE    = 16;
  localparam int          CNT_W         = 12;
  localparam logic [11:0] HALF_A        = 12'(XTAL_A_HZ / BIT_RATE / 2);
  localparam logic [11:0] HALF_B        = 12'(XTAL_B_HZ / BIT_RATE / 2);
  localparam logic [11:0] SAMP_A        = 12'(XTAL_A_HZ / BIT_RATE / OVERSAMPLE);
  localparam logic [11:0] SAMP_B        = 12'(XTAL_B_HZ / BIT_RATE / OVERSAMPLE);
  localparam logic [3:0]  PHASE_CENTER  = 4'h8;
  // Pin input indices.
  localparam int          NUM_IN        = 7;
  localparam int          IN_SCK        = 0;
  localparam int          IN_STB        = 1;
  localparam int          IN_DIN        = 2;
  localparam int          IN_SEL        = 3;
  localparam int          IN_TEST       = 4;
  localparam int          IN_CLR        = 5;
  localparam int          IN_RXD        = 6;
  // Receive buffer.
  localparam int          FIFO_DEPTH    = 16;
  localparam int          FIFO_W        = 1;
endpackage : msk_pkg
`default_nettype wire

// ==== shared/msk_fifo_if.sv ====
/*
  Valid/ready carrier between the receive path and its bit buffer.
  Assumes one clock shared by both sides.
*/
`default_nettype none
interface msk_fifo_if #(parameter int W = 1);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;
  modport src  (output push_valid, output push_data, input push_ready);
  modport snk  (input pop_valid, input pop_data, output pop_ready);
  modport fifo (input push_valid, input push_data, output push_ready,
                output pop_valid, output pop_data, input pop_ready);
endinterface : msk_fifo_if
`default_nettype wire

// ==== rtl/msk_fifo.sv ====
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes synchronous active-low reset on the shared clock.
*/
`default_nettype none
module msk_fifo #(
  parameter int W     = msk_pkg::FIFO_W,
  parameter int DEPTH = msk_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Buffer ports
  msk_fifo_if.fifo  bus
);
  import msk_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wptr;
    logic [AW-1:0]           rptr;
    logic [CW-1:0]           count;
  } msk_fifo_s;

  msk_fifo_s st_reg;
  msk_fifo_s st_next;
  logic      do_push;
  logic      do_pop;

  assign bus.push_ready = (st_reg.count != FULL);
  assign bus.pop_valid  = (st_reg.count != '0);
  assign bus.pop_data   = st_reg.mem[st_reg.rptr];
  assign do_push        = bus.push_valid && bus.push_ready;
  assign do_pop         = bus.pop_ready && bus.pop_valid;

  always_comb begin
    st_next = st_reg;
    if (do_push) begin
      st_next.mem[st_reg.wptr] = bus.push_data;
      st_next.wptr             = st_reg.wptr + 1'b1;
    end
    if (do_pop) begin
      st_next.rptr = st_reg.rptr + 1'b1;
    end
    st_next.count = st_reg.count + CW'(do_push) - CW'(do_pop);
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // msk_fifo
`default_nettype wire

// ==== rtl/msk_modem_ctl.sv ====
/*
  Digital control and receive logic of a 1200 bps MSK modem: serial
  configuration port, control word decode, divider, receive clock recovery,
  receive bit buffer and frame pattern detector.
  Assumes i_clk is the crystal oscillator clock and all pins are asynchronous.
*/
// Functional notes
// R1: Flag rises when received bits equal pattern.
// R2: Recovery loop makes receive clock, presents data.
// R3: Settings only through four-line serial port.
// R4: Host loads control word with select low.
// R5: Reset makes control word 0x0004.
// R6: Bits 2..0 are standby mode number.
// R7: Each standby mode powers down its blocks.
// R8: During reset oscillator-only standby applies.
// R9: Bits 4,3 mute transmit and receive.
// R10: Bits 6,5 bypass de- and pre-emphasis.
// R11: Bit 7 bypasses the compander.
// R12: Bit 8 picks tone detector source.
// R13: Bit 9 picks crystal, sets dividers.
// R14: Host writes zero to bits 12, 13.
// R15: Sixteen-bit pattern loaded and held.
// R16: Host loads pattern with select high.
// R17: Timing clocks divided from the oscillator.
// R18: Data sampled on shift clock rise.
// R19: Strobe rise validates the shifted word.
// R20: Low clear input forces flag low.
// R21: Test low loads fixed pattern instead.
// R22: Strobe moves last sixteen bits by select.
// R23: Flag stays high until clear or reset.
`default_nettype none
module msk_modem_ctl #(
  parameter logic [15:0] FIXED_PATTERN = 16'h5a3c
) (
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_resetn,
  // Serial configuration port
  input  wire logic                    i_serial_cfg_data,
  input  wire logic                    i_serial_cfg_shift_clock,
  input  wire logic                    i_serial_cfg_strobe,
  input  wire logic                    i_pattern_select,
  input  wire logic                    i_test_select,
  output logic                         o_serial_cfg_data_out,
  // Frame detection
  input  wire logic                    i_frame_flag_clear_n,
  output logic                         o_frame_match_flag,
  // Receive data
  input  wire logic                    i_rx_demod_data,
  output logic                         o_recovered_rx_clock,
  output logic                         o_rx_data,
  output logic                         o_rx_overrun,
  // Control outputs
  output logic [2:0]                   o_standby_mode_number,
  output logic                         o_tx_voice_pd,
  output logic                         o_modulator_pd,
  output logic                         o_rx_front_pd,
  output logic                         o_rx_voice_pd,
  output logic                         o_demod_pd,
  output logic                         o_osc_pd,
  output logic                         o_ref_pd,
  output logic                         o_tx_mute,
  output logic                         o_rx_mute,
  output logic                         o_deemph_bypass,
  output logic                         o_preemph_bypass,
  output logic                         o_compander_bypass,
  output logic                         o_tone_src_demod,
  output logic                         o_xtal_alt,
  output logic [msk_pkg::TEST_W-1:0]   o_test_field,
  output logic                         o_modem_clock
);
  import msk_pkg::*;

  typedef struct packed {
    logic [NUM_IN-1:0][2:0] sync;
    logic [NUM_IN-1:0]      filt;
    logic [15:0]            shift_reg;
    logic [15:0]            ctrl_reg;
    logic [15:0]            pattern_reg;
    logic [15:0]            hist;
    logic                   dout;
    logic [CNT_W-1:0]       div_cnt;
    logic [CNT_W-1:0]       samp_cnt;
    logic                   mod_clk;
    logic [3:0]             phase;
    logic                   last_rx;
    logic                   recovered_rx_clock;
    logic                   rd;
    logic                   flag;
    logic                   overrun;
  } msk_state_s;

  msk_state_s        st_reg;
  msk_state_s        st_next;
  logic [NUM_IN-1:0] pins;
  logic [NUM_IN-1:0] rise;
  logic [2:0]        mode;
  logic              osc_pd;
  logic              demod_pd;
  logic              push_v;
  logic              pop_r;
  logic              rd_update;
  logic [3:0]        ph;

  msk_fifo_if #(.W(FIFO_W)) rxq ();

  msk_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .bus      (rxq.fifo)
  );

  assign pins[IN_SCK]  = i_serial_cfg_shift_clock;
  assign pins[IN_STB]  = i_serial_cfg_strobe;
  assign pins[IN_DIN]  = i_serial_cfg_data;
  assign pins[IN_SEL]  = i_pattern_select;
  assign pins[IN_TEST] = i_test_select;
  assign pins[IN_CLR]  = i_frame_flag_clear_n;
  assign pins[IN_RXD]  = i_rx_demod_data;

  // A pin change counts only once the second and third stages agree.
  for (genvar g = 0; g < NUM_IN; g++) begin : g_edge
    assign rise[g] = (st_reg.sync[g][1] == st_reg.sync[g][2]) && st_reg.sync[g][2]
                     && !st_reg.filt[g];
  end

  // Reset value of the control word keeps the oscillator-only mode in reset.
  assign mode     = st_reg.ctrl_reg[STBY_LSB +: STBY_W]; // R6 R8
  assign osc_pd   = (mode > MODE_OSC_ONLY); // R7
  assign demod_pd = (mode == MODE_NO_MODEM) || (mode >= MODE_OSC_ONLY); // R7

  // The buffer costs one bit of latency; a full buffer drops the bit and sets
  // the sticky overrun flag instead of stalling the sampler.
  assign rxq.push_valid = push_v;
  assign rxq.push_data  = st_reg.filt[IN_RXD];
  assign rxq.pop_ready  = pop_r;

  always_comb begin
    st_next   = st_reg;
    push_v    = 1'b0;
    pop_r     = 1'b0;
    rd_update = 1'b0;
    ph        = st_reg.phase + 4'h1;
    for (int i = 0; i < NUM_IN; i++) begin
      st_next.sync[i] = {st_reg.sync[i][1:0], pins[i]};
      if (st_reg.sync[i][1] == st_reg.sync[i][2]) begin
        st_next.filt[i] = st_reg.sync[i][2];
      end
    end
    // Serial configuration port.
    if (rise[IN_SCK]) begin
      if (st_reg.filt[IN_TEST]) begin
        st_next.shift_reg = {st_reg.shift_reg[14:0], st_reg.filt[IN_DIN]}; // R18 R3
        st_next.dout      = st_reg.shift_reg[15];
      end else begin
        st_next.shift_reg = FIXED_PATTERN; // R21
      end
    end
    if (rise[IN_STB]) begin
      if (st_reg.filt[IN_SEL]) begin
        st_next.pattern_reg = st_reg.shift_reg; // R19 R22 R15
      end else begin
        st_next.ctrl_reg = st_reg.shift_reg; // R19 R22
      end
    end
    // Timing divider, stopped when the oscillator is powered down.
    if (!osc_pd) begin
      if (st_reg.div_cnt >= (st_reg.ctrl_reg[XTAL_BIT] ? HALF_B : HALF_A) - 12'h001) begin
        st_next.div_cnt = '0; // R13 R17
        st_next.mod_clk = !st_reg.mod_clk;
      end else begin
        st_next.div_cnt = st_reg.div_cnt + 12'h001;
      end
    end
    // Clock recovery: transitions pull the phase toward zero.
    if (!demod_pd) begin
      if (st_reg.samp_cnt >= (st_reg.ctrl_reg[XTAL_BIT] ? SAMP_B : SAMP_A) - 12'h001) begin
        st_next.samp_cnt = '0;
        st_next.last_rx  = st_reg.filt[IN_RXD];
        if ((st_reg.filt[IN_RXD] != st_reg.last_rx) && (st_reg.phase != 4'h0)) begin
          ph = st_reg.phase[3] ? st_reg.phase + 4'h2 : st_reg.phase; // R2
        end
        st_next.phase = ph;
        st_next.recovered_rx_clock   = ph[3]; // R2
        if (ph == PHASE_CENTER) begin
          push_v = 1'b1;
          if (!rxq.push_ready) begin
            st_next.overrun = 1'b1;
          end
          pop_r = 1'b1;
          if (rxq.pop_valid) begin
            st_next.rd = rxq.pop_data[0]; // R2
            rd_update  = 1'b1;
          end
        end
      end else begin
        st_next.samp_cnt = st_reg.samp_cnt + 12'h001;
      end
    end
    // Frame detector; a low clear input wins over a same-cycle match.
    if (rd_update) begin
      st_next.hist = {st_reg.hist[14:0], rxq.pop_data[0]};
      if ({st_reg.hist[14:0], rxq.pop_data[0]} == st_reg.pattern_reg) begin
        st_next.flag = 1'b1; // R1 R23
      end
    end
    if (!st_reg.filt[IN_CLR]) begin
      st_next.flag = 1'b0; // R20
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      st_reg          <= '0;
      st_reg.ctrl_reg <= CTRL_RESET; // R5 R8
    end else begin
      st_reg <= st_next;
    end
  end

  // Control outputs are levels decoded from the word, so a new word acts one
  // clock after its strobe edge is recognized.
  assign o_serial_cfg_data_out = st_reg.dout;
  assign o_frame_match_flag    = st_reg.flag;
  assign o_recovered_rx_clock  = st_reg.recovered_rx_clock;
  assign o_rx_data             = st_reg.rd;
  assign o_rx_overrun          = st_reg.overrun;
  assign o_modem_clock         = st_reg.mod_clk;
  assign o_standby_mode_number = mode;
  assign o_tx_voice_pd         = (mode >= MODE_NO_TX); // R7
  assign o_modulator_pd        = (mode != MODE_ALL_ON); // R7
  assign o_rx_voice_pd         = (mode >= MODE_NO_RXVF); // R7
  assign o_rx_front_pd         = (mode >= MODE_OSC_ONLY); // R7
  assign o_ref_pd              = (mode >= MODE_OSC_ONLY); // R7
  assign o_demod_pd            = demod_pd;
  assign o_osc_pd              = osc_pd;
  assign o_tx_mute             = st_reg.ctrl_reg[TXMUTE_BIT]; // R9
  assign o_rx_mute             = st_reg.ctrl_reg[RXMUTE_BIT]; // R9
  assign o_deemph_bypass       = st_reg.ctrl_reg[DEEMPH_BIT]; // R10
  assign o_preemph_bypass      = st_reg.ctrl_reg[PREEMPH_BIT]; // R10
  assign o_compander_bypass    = st_reg.ctrl_reg[COMP_BIT]; // R11
  assign o_tone_src_demod      = st_reg.ctrl_reg[TONE_BIT]; // R12
  assign o_xtal_alt            = st_reg.ctrl_reg[XTAL_BIT]; // R13
  assign o_test_field          = st_reg.ctrl_reg[TEST_LSB +: TEST_W];

  // Checks.
  // Load checks watch filtered edges, since pins count three clocks late.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  property p_reset_word;
    disable iff (1'b0) !i_resetn |=> (o_standby_mode_number == MODE_OSC_ONLY) && !o_tx_mute
      && !o_rx_mute && !o_compander_bypass && !o_xtal_alt && (o_test_field == '0);
  endproperty
  a_reset_word: assert property (p_reset_word) else $error("reset word wrong"); // R5

  property p_reset_mode;
    disable iff (1'b0) !i_resetn |=> o_rx_front_pd && !o_osc_pd && o_demod_pd;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("reset mode not 4"); // R8

  property p_flag_set;
    (rd_update && st_reg.filt[IN_CLR]
      && ({st_reg.hist[14:0], rxq.pop_data[0]} == st_reg.pattern_reg)) |=> o_frame_match_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("match did not raise flag"); // R1

  property p_flag_hold;
    (o_frame_match_flag && st_reg.filt[IN_CLR]) |=> o_frame_match_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped"); // R23

  property p_flag_clear;
    !st_reg.filt[IN_CLR] |=> !o_frame_match_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("clear ignored"); // R20

  property p_rd_at_rck;
    !$stable(o_rx_data) |-> $rose(o_recovered_rx_clock);
  endproperty
  a_rd_at_rck: assert property (p_rd_at_rck) else $error("data moved off clock edge"); // R2

  property p_strobe_load;
    (rise[IN_STB] && !st_reg.filt[IN_SEL]) |=> (st_reg.ctrl_reg == $past(st_reg.shift_reg));
  endproperty
  a_strobe_load: assert property (p_strobe_load) else $error("control not loaded"); // R19

  property p_pattern_load;
    (rise[IN_STB] && st_reg.filt[IN_SEL])
      |=> (st_reg.pattern_reg == $past(st_reg.shift_reg)) && $stable(st_reg.ctrl_reg);
  endproperty
  a_pattern_load: assert property (p_pattern_load) else $error("pattern not loaded"); // R22

  property p_fixed;
    (rise[IN_SCK] && !st_reg.filt[IN_TEST]) |=> (st_reg.shift_reg == FIXED_PATTERN);
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed pattern missing"); // R21

  property p_osc_only;
    (mode == MODE_OSC_ONLY) |-> o_tx_voice_pd && o_rx_voice_pd && o_ref_pd && !o_osc_pd;
  endproperty
  a_osc_only: assert property (p_osc_only) else $error("mode 4 decode wrong"); // R7

  property p_divider;
    (!osc_pd && !o_xtal_alt && $rose(o_modem_clock) && $stable(st_reg.ctrl_reg))
      |-> o_modem_clock [*8];
  endproperty
  a_divider: assert property (p_divider) else $error("divider too fast"); // R13

  property p_shift_in;
    (rise[IN_SCK] && st_reg.filt[IN_TEST])
      |=> (st_reg.shift_reg == {$past(st_reg.shift_reg[14:0]), $past(st_reg.filt[IN_DIN])});
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("serial bit not shifted in"); // R18

  property p_ctrl_hold;
    !rise[IN_STB] |=> $stable(st_reg.ctrl_reg) && $stable(st_reg.pattern_reg);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("settings moved without strobe"); // R15 R19

  property p_demod_halt;
    demod_pd |=> $stable(o_recovered_rx_clock) && $stable(o_rx_data);
  endproperty
  a_demod_halt: assert property (p_demod_halt) else $error("receive ran while powered down"); // R7

  property p_osc_halt;
    osc_pd |=> $stable(o_modem_clock);
  endproperty
  a_osc_halt: assert property (p_osc_halt) else $error("divider ran while powered down"); // R17

  property p_rck_high;
    $rose(o_recovered_rx_clock) |-> o_recovered_rx_clock [*8];
  endproperty
  a_rck_high: assert property (p_rck_high) else $error("receive clock high too short"); // R2

  property p_mode1;
    (mode == MODE_NO_MODEM) |-> o_demod_pd && o_modulator_pd && !o_tx_voice_pd && !o_osc_pd;
  endproperty
  a_mode1: assert property (p_mode1) else $error("mode 1 decode wrong"); // R7

  c_ctrl_load: cover property (rise[IN_STB] && !st_reg.filt[IN_SEL]);
  c_pat_load:  cover property (rise[IN_STB] && st_reg.filt[IN_SEL]);
  c_match:     cover property ($rose(o_frame_match_flag));
  c_overrun:   cover property ($rose(o_rx_overrun));
endmodule // msk_modem_ctl
`default_nettype wire

// ==== tb/msk_host_model.sv ====
/*
  Host processor model that drives the serial configuration port pins.
  Assumes the bench calls its tasks only after reset has been released.
*/
`default_nettype none
module msk_host_model (
  // Clock
  input  wire logic i_clk,
  // Serial port pins and frame flag clear pin
  output logic      o_data,
  output logic      o_sck,
  output logic      o_stb,
  output logic      o_sel,
  output logic      o_test,
  output logic      o_clr_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins pass a three-flop filter, so every level is held for six clocks.
  localparam int HOLD = 6;

  initial begin
    o_data  = 1'b0;
    o_sck   = 1'b0;
    o_stb   = 1'b0;
    o_sel   = 1'b0;
    o_test  = 1'b1;
    o_clr_n = 1'b1;
  end

  task automatic step();
    repeat (HOLD) @(posedge i_clk);
  endtask

  // Twenty bits go out, so the last sixteen must be the ones kept.
  task automatic load(input logic [19:0] bits, input logic sel, input logic ext);
    o_sel  <= sel;
    o_test <= ext;
    step();
    for (int i = 19; i >= 0; i--) begin
      o_data <= bits[i];
      step();
      o_sck <= 1'b1;
      step();
      o_sck  <= 1'b0;
      o_data <= ~bits[i];
      step();
    end
    o_stb <= 1'b1;
    step();
    o_stb <= 1'b0;
    step();
  endtask

  task automatic clear();
    o_clr_n <= 1'b0;
    step();
    o_clr_n <= 1'b1;
    step();
  endtask
endmodule // msk_host_model
`default_nettype wire

// ==== tb/msk_modem_serial_control_tb_top.sv ====
/*
  Self-checking bench for the modem control block with a host port model.
  Assumes the receive stream runs at the alternate crystal bit period.
*/
`default_nettype none
module msk_modem_serial_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import msk_pkg::*;
  localparam logic [15:0] FIX      = 16'h0302;
  localparam int          BIT_CLKS = XTAL_B_HZ / BIT_RATE;
  logic        i_clk;
  logic        i_resetn;
  logic        rxd;
  logic        sdat, sck, stb, sel, tst, clr_n;
  logic        dout, flag, recovered_rx_clock, rdat, ovr, mclk;
  wire  [15:0] obs;
  wire  [6:0]  pd;
  logic [31:0] hist;
  logic        rck_q;
  logic [15:0] w;
  logic [15:0] pat;
  logic [3:0]  pre;
  int          num_errors;
  int          checked;
  int          cnt;
  int          tog;
  logic        prev;

  msk_modem_ctl #(.FIXED_PATTERN(FIX)) u_dut (
    .i_clk(i_clk), .i_resetn(i_resetn),
    .i_serial_cfg_data(sdat), .i_serial_cfg_shift_clock(sck),
    .i_serial_cfg_strobe(stb), .i_pattern_select(sel), .i_test_select(tst),
    .o_serial_cfg_data_out(dout), .i_frame_flag_clear_n(clr_n),
    .o_frame_match_flag(flag), .i_rx_demod_data(rxd), .o_recovered_rx_clock(recovered_rx_clock),
    .o_rx_data(rdat), .o_rx_overrun(ovr), .o_standby_mode_number(obs[2:0]),
    .o_tx_voice_pd(pd[6]), .o_modulator_pd(pd[5]), .o_rx_front_pd(pd[4]),
    .o_rx_voice_pd(pd[3]), .o_demod_pd(pd[2]), .o_osc_pd(pd[1]), .o_ref_pd(pd[0]),
    .o_tx_mute(obs[4]), .o_rx_mute(obs[3]), .o_deemph_bypass(obs[6]),
    .o_preemph_bypass(obs[5]), .o_compander_bypass(obs[7]), .o_tone_src_demod(obs[8]),
    .o_xtal_alt(obs[9]), .o_test_field(obs[15:10]), .o_modem_clock(mclk)
  );

  msk_host_model u_host (
    .i_clk(i_clk), .o_data(sdat), .o_sck(sck), .o_stb(stb),
    .o_sel(sel), .o_test(tst), .o_clr_n(clr_n)
  );

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    rck_q <= recovered_rx_clock;
    if (recovered_rx_clock === 1'b1 && rck_q === 1'b0) begin
      hist <= {hist[30:0], rdat};
    end
  end

  function automatic logic [6:0] exp_pd(input logic [2:0] m);
    return {m >= 3'h2, m != 3'h0, m >= 3'h4, m >= 3'h3, m == 3'h1 || m >= 3'h4,
            m >= 3'h5, m >= 3'h4};
  endfunction

  function automatic logic has_pat(input logic [31:0] h, input logic [15:0] p);
    for (int k = 0; k <= 16; k++) begin
      if (h[k+:16] === p) return 1'b1;
    end
    return 1'b0;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic check_ctl(input logic [15:0] e);
    check("control outputs", {16'h0000, obs}, {16'h0000, e});
    check("power downs", {25'h0, pd}, {25'h0, exp_pd(e[2:0])});
  endtask

  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask

  task automatic wait_clk(input logic v, output int n);
    n = 0;
    while (mclk !== v && n < 4000) begin
      tick();
      n++;
    end
    if (n >= 4000) begin
      num_errors++;
      finish_test();
    end
  endtask

  task automatic send_bit(input logic b);
    rxd <= b;
    repeat (BIT_CLKS) @(posedge i_clk);
  endtask

  task automatic finish_test();
    $display("Checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (98000) @(posedge i_clk);
    num_errors++;
    finish_test();
  end

  initial begin
    num_errors = 0;
    checked    = 0;
    hist       = 32'h0;
    i_resetn   = 1'b0;
    rxd        = 1'b0;
    void'($urandom(51));
    repeat (6) tick();
    check_ctl(16'h0004);
    check("frame flag", {31'h0, flag}, 32'h0);
    i_resetn <= 1'b1;
    repeat (5) tick();
    for (int m = 0; m < 6; m++) begin
      pre = 4'($urandom);
      w   = (16'($urandom) & 16'hcff8) | 16'(m);
      u_host.load({pre, w}, 1'b0, 1'b1);
      tick();
      check_ctl(w);
      check("serial data out", {31'h0, dout}, {31'h0, pre[0]});
    end
    u_host.load(20'($urandom), 1'b0, 1'b0);
    tick();
    check_ctl(FIX);
    for (int x = 0; x < 2; x++) begin
      w = (x == 1) ? 16'h0200 : 16'h0000;
      u_host.load({4'h0, w}, 1'b0, 1'b1);
      wait_clk(1'b0, cnt);
      wait_clk(1'b1, cnt);
      wait_clk(1'b0, cnt);
      check("modem half period", cnt, ((x == 1) ? XTAL_B_HZ : XTAL_A_HZ) / BIT_RATE / 2);
    end
    u_host.load({4'h0, 16'h0201}, 1'b0, 1'b1);
    tog  = 0;
    prev = recovered_rx_clock;
    for (int i = 0; i < 2 * BIT_CLKS; i++) begin
      if (i % 500 == 0) rxd <= ~rxd;
      tick();
      if (recovered_rx_clock !== prev) tog++;
      prev = recovered_rx_clock;
    end
    check("clock toggles with demod off", tog, 0);
    pat = {16'($urandom) & 16'hfffc} | 16'h0001;
    u_host.load({4'h0, pat}, 1'b1, 1'b1);
    u_host.load({4'h0, 16'h0200}, 1'b0, 1'b1);
    u_host.clear();
    check("flag after clear", {31'h0, flag}, 32'h0);
    // A 1010 preamble gives the recovery loop transitions to lock on.
    for (int i = 3; i >= 0; i--) send_bit(i[0]);
    for (int i = 15; i >= 0; i--) send_bit(pat[i]);
    send_bit(~pat[0]);
    send_bit(pat[0]);
    check("received data", {31'h0, has_pat(hist, pat)}, 32'h1);
    check("frame flag on match", {31'h0, flag}, 32'h1);
    send_bit(~pat[0]);
    send_bit(pat[0]);
    send_bit(~pat[0]);
    check("frame flag held", {31'h0, flag}, 32'h1);
    u_host.clear();
    check("frame flag cleared", {31'h0, flag}, 32'h0);
    check("overrun", {31'h0, ovr}, 32'h0);
    finish_test();
  end
endmodule // msk_modem_serial_control_tb_top
`default_nettype wire
